// ===== sbi_sys_if.sv
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sbi_sys_if
   import sbi_pkg::*;
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // system interface buses
   input wire logic [31:0] addr_data_bus_in,
   output logic [31:0] addr_data_bus_out,
   output logic addr_data_bus_oe_n,
   input wire logic [8:0] cmd_ident_bus_in,
   output logic [8:0] cmd_ident_bus_out,
   output logic cmd_ident_bus_oe_n,
   input wire logic [3:0] addr_data_check_bus_in,
   output logic [3:0] addr_data_check_bus_out,
   output logic addr_data_check_bus_oe_n,
   input wire logic cmd_bus_parity_in,
   output logic cmd_bus_parity_out,
   output logic cmd_bus_parity_oe_n,
   // system interface handshakes
   input wire logic agent_valid_n,
   output logic proc_valid_n,
   input wire logic agent_bus_request_n,
   output logic release_n,
   input wire logic write_accept_n,
   input wire logic read_accept_n,
   // clock and control pins
   input wire logic [1:0] clock_ratio_strap,
   input wire logic timer_irq_disable,
   output logic low_power,
   input wire logic pll_stop_n,
   output logic core_clk_run,
   input wire logic byte_order_strap,
   output logic big_endian,
   // interrupts
   input wire logic [5:0] irq_in_n,
   input wire logic nmi_in_n
);
   typedef struct packed {
      sbi_phase_t phase;
      logic straps_taken;
      logic [1:0] ratio;
      logic big_endian;
      logic [1:0] pwr_mode;
      logic low_power;
      logic pll_run;
      logic [5:0] irq_q;
      logic nmi_q;
      logic nmi_pend;
      logic timer_pend;
      logic par_err;
      logic [31:0] timer_cnt;
      logic [31:0] timer_cmp;
      logic [31:0] req_addr;
      logic [31:0] req_wdata;
      logic [8:0] req_cmd;
      logic req_write;
      logic [8:0] data_id;
      logic [31:0] rx_data;
      logic [8:0] rx_cmd;
      logic rx_valid;
      logic [31:0] ad_out;
      logic [8:0] cmd_out;
      logic [3:0] chk_out;
      logic bus_oe_n;
      logic proc_valid_n;
      logic release_n;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sbi_state_t;

   sbi_state_t s;
   sbi_state_t next_s;
   logic [3:0] tx_par;
   logic [3:0] rx_par;
   logic [5:0] pend;

   // per-lane parity, outgoing write data and incoming bus
   for (genvar g = 0; g < SBI_CHK_W; g++)
   begin : g_par
      sbi_parity #(.W(8)) u_tx (.data(s.req_wdata[g*8 +: 8]), .parity(tx_par[g]));
      sbi_parity #(.W(8)) u_rx (.data(addr_data_bus_in[g*8 +: 8]), .parity(rx_par[g]));
   end

   // line 5 is either the timer or the pin, never both
   assign pend = {timer_irq_disable ? s.irq_q[5] : s.timer_pend, s.irq_q[4:0]};

   // byte-lane merge for partial axi writes
   function automatic logic [31:0] sbi_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : sbi_merge

   // register read view
   function automatic logic [31:0] sbi_read(input sbi_state_t st, input logic [7:0] a,
                                            input logic [5:0] pv, input logic tdis);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         SBI_CTRL: r = {29'h0, st.big_endian, st.pwr_mode};
         SBI_ADDR: r = st.req_addr;
         SBI_WDATA: r = st.req_wdata;
         SBI_CMD: r = {22'h0, st.req_write, st.req_cmd};
         SBI_DATA_ID: r = {23'h0, st.data_id};
         SBI_STATUS: r = {23'h0, st.rx_valid, tdis, st.low_power, st.big_endian,
                          st.pll_run, st.ratio, st.phase != SBI_AGENT,
                          st.phase != SBI_IDLE && st.phase != SBI_AGENT};
         SBI_EVENTS: r = {23'h0, st.par_err, st.timer_pend, st.nmi_pend, pv};
         SBI_RX_DATA: r = st.rx_data;
         SBI_RX_CMD: r = {23'h0, st.rx_cmd};
         SBI_TIMER_CMP: r = st.timer_cmp;
         SBI_CLK_MULT:
         begin
            unique case (st.ratio)
               2'h0: r = {28'h0, SBI_MULT_R0};
               2'h1: r = {28'h0, SBI_MULT_R1};
               2'h2: r = {28'h0, SBI_MULT_R2};
               2'h3: r = {28'h0, SBI_MULT_R3};
            endcase
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction : sbi_read

   // next-state logic; later sections win, so hardware sets beat software clears
   always_comb
   begin
      logic [31:0] wv;
      logic rd_ok;
      wv = 32'h0000_0000;
      rd_ok = 1'b0;
      next_s = s;
      // straps caught once, on the first enabled edge after reset
      if (!s.straps_taken)
      begin
         next_s.straps_taken = 1'b1;
         next_s.ratio = clock_ratio_strap;
         next_s.big_endian = byte_order_strap;
      end
      // axi write channels, taken in either order
      if (s_axi_awvalid && s.awready)
      begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
      begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_held && s.w_held && !s.bvalid)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = SBI_RESP_OKAY;
         wv = sbi_merge(sbi_read(s, s.aw_addr, pend, timer_irq_disable), s.w_data, s.w_strb);
         unique case (s.aw_addr)
            SBI_CTRL:
            begin
               next_s.pwr_mode = wv[1:0];
               next_s.low_power = wv[1:0] == SBI_PWR_HALT || wv[1:0] == SBI_PWR_DOZE;
               next_s.big_endian = wv[SBI_CTRL_ENDIAN];
            end
            SBI_ADDR: next_s.req_addr = wv;
            SBI_WDATA: next_s.req_wdata = wv;
            SBI_DATA_ID: next_s.data_id = wv[8:0];
            SBI_TIMER_CMP: next_s.timer_cmp = wv;
            SBI_CMD:
            begin
               // launch only when idle and not yielding to the agent
               if (s.phase == SBI_IDLE && agent_bus_request_n && !s.low_power)
               begin
                  next_s.req_cmd = wv[8:0];
                  next_s.req_write = wv[SBI_CMD_WRITE];
                  next_s.phase = SBI_WAIT_RDY;
               end
               else
               begin
                  next_s.bresp = SBI_RESP_SLVERR;
               end
            end
            SBI_EVENTS:
            begin
               // write one to clear
               next_s.nmi_pend = s.nmi_pend & ~s.w_data[SBI_EV_NMI];
               next_s.timer_pend = s.timer_pend & ~s.w_data[SBI_EV_TIMER];
               next_s.par_err = s.par_err & ~s.w_data[SBI_EV_PARERR];
            end
            SBI_STATUS, SBI_RX_DATA, SBI_RX_CMD, SBI_CLK_MULT:
            begin
               next_s.bresp = SBI_RESP_OKAY;
            end
            default: next_s.bresp = SBI_RESP_SLVERR;
         endcase
      end
      // axi read: answer one cycle after the address is taken
      if (s.rvalid && s_axi_rready)
      begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready)
      begin
         unique case (s_axi_araddr)
            SBI_CTRL, SBI_ADDR, SBI_WDATA, SBI_CMD, SBI_DATA_ID, SBI_STATUS, SBI_EVENTS,
            SBI_RX_DATA, SBI_RX_CMD, SBI_TIMER_CMP, SBI_CLK_MULT: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
         endcase
         next_s.rvalid = 1'b1;
         next_s.rdata = sbi_read(s, s_axi_araddr, pend, timer_irq_disable);
         next_s.rresp = rd_ok ? SBI_RESP_OKAY : SBI_RESP_SLVERR;
         if (s_axi_araddr == SBI_RX_DATA)
         begin
            next_s.rx_valid = 1'b0;
         end
      end
      // pin sampling on every enabled edge
      next_s.irq_q = ~irq_in_n;
      next_s.nmi_q = ~nmi_in_n;
      next_s.pll_run = pll_stop_n;
      if (!nmi_in_n && !s.nmi_q)
      begin
         next_s.nmi_pend = 1'b1;
      end
      // timer counts only while the generator runs and the timer is enabled
      if (!timer_irq_disable && s.pll_run)
      begin
         if (s.timer_cnt == s.timer_cmp)
         begin
            next_s.timer_cnt = 32'h0000_0000;
            next_s.timer_pend = 1'b1;
         end
         else
         begin
            next_s.timer_cnt = s.timer_cnt + 32'h0000_0001;
         end
      end
      // any pending interrupt ends halt or doze
      if (s.low_power && (|pend || s.nmi_pend))
      begin
         next_s.pwr_mode = SBI_PWR_RUN;
         next_s.low_power = 1'b0;
      end
      // system interface sequencer
      next_s.release_n = 1'b1;
      next_s.cmd_out = s.cmd_out;
      unique case (s.phase)
         SBI_IDLE:
         begin
            if (!agent_bus_request_n)
            begin
               next_s.release_n = 1'b0;
               next_s.bus_oe_n = 1'b1;
               next_s.phase = SBI_AGENT;
            end
         end
         SBI_WAIT_RDY:
         begin
            // a stopped clock generator holds the request back
            if (s.pll_run && (s.req_write ? !write_accept_n : !read_accept_n))
            begin
               next_s.ad_out = s.req_addr;
               next_s.cmd_out = s.req_cmd;
               next_s.chk_out = 4'h0;
               next_s.proc_valid_n = 1'b0;
               next_s.phase = SBI_ADDR_CYC;
            end
         end
         SBI_ADDR_CYC:
         begin
            if (s.req_write)
            begin
               next_s.ad_out = s.req_wdata;
               next_s.cmd_out = s.data_id;
               next_s.chk_out = tx_par;
               next_s.phase = SBI_DATA_CYC;
            end
            else
            begin
               // hand the bus lines to the agent for the read answer
               next_s.bus_oe_n = 1'b1;
               next_s.proc_valid_n = 1'b1;
               next_s.phase = SBI_RD_WAIT;
            end
         end
         SBI_DATA_CYC:
         begin
            next_s.proc_valid_n = 1'b1;
            next_s.ad_out = 32'h0000_0000;
            next_s.chk_out = 4'h0;
            next_s.phase = SBI_IDLE;
         end
         SBI_RD_WAIT:
         begin
            if (!agent_valid_n)
            begin
               next_s.rx_data = addr_data_bus_in;
               next_s.rx_cmd = cmd_ident_bus_in;
               next_s.rx_valid = 1'b1;
               if (rx_par != addr_data_check_bus_in)
               begin
                  next_s.par_err = 1'b1;
               end
               next_s.bus_oe_n = 1'b0;
               next_s.phase = SBI_IDLE;
            end
         end
         SBI_AGENT:
         begin
            // words the agent puts out while it owns the bus
            if (!agent_valid_n)
            begin
               next_s.rx_data = addr_data_bus_in;
               next_s.rx_cmd = cmd_ident_bus_in;
               next_s.rx_valid = 1'b1;
            end
            if (agent_bus_request_n)
            begin
               next_s.bus_oe_n = 1'b0;
               next_s.phase = SBI_IDLE;
            end
         end
      endcase
      // ready flags follow the held state, so they stay registered
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // state register; reset acts even with the enable low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.phase <= SBI_IDLE;
         s.timer_cmp <= SBI_TIMER_CMP_RST;
         s.pll_run <= 1'b0;
         s.bus_oe_n <= 1'b0;
         s.proc_valid_n <= 1'b1;
         s.release_n <= 1'b1;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // pins straight from the state register; command parity pin tied low
   assign addr_data_bus_out = s.ad_out;
   assign addr_data_bus_oe_n = s.bus_oe_n;
   assign cmd_ident_bus_out = s.cmd_out;
   assign cmd_ident_bus_oe_n = s.bus_oe_n;
   assign addr_data_check_bus_out = s.chk_out;
   assign addr_data_check_bus_oe_n = s.bus_oe_n;
   assign cmd_bus_parity_out = 1'b0;
   assign cmd_bus_parity_oe_n = s.bus_oe_n;
   assign proc_valid_n = s.proc_valid_n;
   assign release_n = s.release_n;
   assign low_power = s.low_power;
   assign core_clk_run = s.pll_run;
   assign big_endian = s.big_endian;
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
endmodule : sbi_sys_if

// ===== sbi_pkg.sv
package sbi_pkg;
   localparam int SBI_AD_W = 32;
   localparam int SBI_CMD_W = 9;
   localparam int SBI_CHK_W = 4;
   localparam int SBI_AXI_AW = 8;
   // register byte offsets
   localparam logic [7:0] SBI_CTRL = 8'h00;
   localparam logic [7:0] SBI_ADDR = 8'h04;
   localparam logic [7:0] SBI_WDATA = 8'h08;
   localparam logic [7:0] SBI_CMD = 8'h0c;
   localparam logic [7:0] SBI_DATA_ID = 8'h10;
   localparam logic [7:0] SBI_STATUS = 8'h14;
   localparam logic [7:0] SBI_EVENTS = 8'h18;
   localparam logic [7:0] SBI_RX_DATA = 8'h1c;
   localparam logic [7:0] SBI_RX_CMD = 8'h20;
   localparam logic [7:0] SBI_TIMER_CMP = 8'h24;
   localparam logic [7:0] SBI_CLK_MULT = 8'h28;
   // field positions
   localparam int SBI_CTRL_ENDIAN = 2;
   localparam int SBI_CMD_WRITE = 9;
   localparam int SBI_EV_NMI = 6;
   localparam int SBI_EV_TIMER = 7;
   localparam int SBI_EV_PARERR = 8;
   // power modes
   localparam logic [1:0] SBI_PWR_RUN = 2'h0;
   localparam logic [1:0] SBI_PWR_HALT = 2'h1;
   localparam logic [1:0] SBI_PWR_DOZE = 2'h2;
   // core clock over master clock, times two, per strap code
   localparam logic [3:0] SBI_MULT_R0 = 4'h8;
   localparam logic [3:0] SBI_MULT_R1 = 4'h5;
   localparam logic [3:0] SBI_MULT_R2 = 4'h4;
   localparam logic [3:0] SBI_MULT_R3 = 4'h6;
   // reset values and axi response codes
   localparam logic [31:0] SBI_TIMER_CMP_RST = 32'h0000_ffff;
   localparam logic [1:0] SBI_RESP_OKAY = 2'h0;
   localparam logic [1:0] SBI_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      SBI_IDLE,
      SBI_WAIT_RDY,
      SBI_ADDR_CYC,
      SBI_DATA_CYC,
      SBI_RD_WAIT,
      SBI_AGENT
   } sbi_phase_t;
endpackage : sbi_pkg

// ===== sbi_parity.sv
`timescale 1ns/1ps
module sbi_parity #(
   parameter int W = 8
) (
   // byte lane in
   input wire logic [W-1:0] data,
   // even parity out
   output logic parity
);
   // even parity: the lane plus its check bit hold an even count of ones
   assign parity = ^data;
endmodule : sbi_parity

// ===== sbi_sys_if_asserts.sv
`timescale 1ns/1ps
module sbi_sys_if_asserts
   import sbi_pkg::*;
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // system interface pins
   input wire logic [31:0] addr_data_bus_out,
   input wire logic addr_data_bus_oe_n,
   input wire logic [3:0] addr_data_check_bus_out,
   input wire logic cmd_bus_parity_out,
   input wire logic proc_valid_n,
   input wire logic agent_bus_request_n,
   input wire logic release_n,
   input wire logic write_accept_n,
   input wire logic read_accept_n,
   // clock and strap pins
   input wire logic pll_stop_n,
   input wire logic core_clk_run,
   input wire logic byte_order_strap,
   input wire logic big_endian
);
   // per-byte even parity of the driven word
   logic [3:0] par;
   assign par = {^addr_data_bus_out[31:24], ^addr_data_bus_out[23:16],
      ^addr_data_bus_out[15:8], ^addr_data_bus_out[7:0]};
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_cmd_par_zero: assert property (cmd_bus_parity_out == 1'h0)
      else $error("command parity pin not zero");
   chk_valid_drives: assert property (!proc_valid_n |-> !addr_data_bus_oe_n)
      else $error("valid out while bus not driven");
   chk_addr_cycle: assert property ($fell(proc_valid_n) |->
      ($past(write_accept_n) == 1'h0 || $past(read_accept_n) == 1'h0)
      && addr_data_check_bus_out == 4'h0)
      else $error("address cycle without accept or with check bits");
   chk_data_parity: assert property (!proc_valid_n && $past(proc_valid_n) == 1'h0
      |-> addr_data_check_bus_out == par)
      else $error("data cycle parity wrong");
   chk_valid_len: assert property (!proc_valid_n ##1 !proc_valid_n |=> proc_valid_n)
      else $error("valid out held over two words");
   chk_release_grant: assert property ($fell(release_n) |->
      ($past(agent_bus_request_n) == 1'h0 && addr_data_bus_oe_n) ##1 release_n)
      else $error("release without request or not a pulse");
   chk_pll_follow: assert property ($past(aresetn) && $past(ce)
      |-> core_clk_run == $past(pll_stop_n))
      else $error("clock run does not follow stop input");
   chk_reset_owner: assert property ($rose(aresetn)
      |-> !addr_data_bus_oe_n && proc_valid_n && release_n)
      else $error("device not bus owner after reset");
   chk_endian_init: assert property ($past(aresetn, 3) == 1'h0 && $past(aresetn, 2)
      && $past(aresetn) |-> big_endian == $past(byte_order_strap))
      else $error("endian not taken from strap");
endmodule : sbi_sys_if_asserts
bind sbi_sys_if sbi_sys_if_asserts i_chk (.*);

// ===== sbi_agent_model.sv
`timescale 1ns/1ps
module sbi_agent_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // device side of the pins
   input wire logic [31:0] addr_data_bus_out,
   input wire logic [8:0] cmd_ident_bus_out,
   input wire logic [3:0] addr_data_check_bus_out,
   input wire logic addr_data_bus_oe_n,
   input wire logic proc_valid_n,
   input wire logic release_n,
   // bench controls
   input wire logic slow,
   input wire logic bad_par,
   input wire logic [31:0] rd_word,
   input wire logic [8:0] rd_cmd,
   // resolved pins toward the device
   output logic [31:0] addr_data_bus_in,
   output logic [8:0] cmd_ident_bus_in,
   output logic [3:0] addr_data_check_bus_in,
   output logic agent_valid_n,
   output logic write_accept_n,
   output logic read_accept_n
);
   int seed = 32'hb8178722;
   logic [31:0] rnd;
   logic [44:0] last;
   logic drv, pend, prev_v;
   logic [1:0] dly;
   // answers a read address or a hand-over with one word, late when slow
   always_ff @(posedge aclk)
   begin
      rnd <= $random(seed);
      prev_v <= proc_valid_n;
      write_accept_n <= slow & rnd[0];
      read_accept_n <= slow & rnd[1];
      drv <= 1'h0;
      last <= {cmd_ident_bus_in, addr_data_check_bus_in, addr_data_bus_in};
      if (!aresetn)
         pend <= 1'h0;
      else if (pend && dly == 2'h0)
      begin
         drv <= 1'h1;
         pend <= 1'h0;
      end
      else if (pend)
         dly <= dly - 2'h1;
      else if (!release_n || (!prev_v && proc_valid_n && addr_data_bus_oe_n))
      begin
         pend <= 1'h1;
         dly <= slow ? 2'h3 : 2'h0;
      end
   end
   assign agent_valid_n = !drv;
   // wire level: device, agent, or a floating bus that inverts its value of the cycle before
   always_comb
   begin
      if (!addr_data_bus_oe_n)
         {cmd_ident_bus_in, addr_data_check_bus_in, addr_data_bus_in} =
            {cmd_ident_bus_out, addr_data_check_bus_out, addr_data_bus_out};
      else if (drv)
         {cmd_ident_bus_in, addr_data_check_bus_in, addr_data_bus_in} = {rd_cmd,
            {^rd_word[31:24] ^ bad_par, ^rd_word[23:16], ^rd_word[15:8], ^rd_word[7:0]},
            rd_word};
      else
         {cmd_ident_bus_in, addr_data_check_bus_in, addr_data_bus_in} = ~last;
   end
endmodule : sbi_agent_model

// ===== sbi_sys_if_tb.sv
`timescale 1ns/1ps
module sbi_sys_if_tb;
   import sbi_pkg::*;
   localparam logic [1:0] OK = SBI_RESP_OKAY;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, a, d;
   logic [3:0] s_axi_wstrb = 4'hf, addr_data_check_bus_in, addr_data_check_bus_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, clock_ratio_strap = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] addr_data_bus_in, addr_data_bus_out, rd_word = 32'h0;
   logic [8:0] cmd_ident_bus_in, cmd_ident_bus_out, rd_cmd = 9'h0, c, id;
   logic addr_data_bus_oe_n, cmd_ident_bus_oe_n, addr_data_check_bus_oe_n;
   logic cmd_bus_parity_oe_n, cmd_bus_parity_out, proc_valid_n, release_n;
   logic low_power, core_clk_run, big_endian, agent_valid_n, write_accept_n, read_accept_n;
   logic cmd_bus_parity_in = 1'h1, agent_bus_request_n = 1'h1, timer_irq_disable = 1'h1;
   logic pll_stop_n = 1'h1, byte_order_strap = 1'h0, nmi_in_n = 1'h1, slow = 1'h0;
   logic bad_par = 1'h0;
   logic [5:0] irq_in_n = 6'h3f, p;
   int err_count = 0, checked = 0, seed = 32'hb8178722;
   logic [63:0] mon[$];
   sbi_sys_if i_dut (.*);
   sbi_agent_model i_agent (.*);
   // free-running bench clock, 50 ns period
   initial
   begin
      forever #25 aclk = ~aclk;
   end
   // words the device puts out, kept for later comparison
   always @(posedge aclk)
      if (!proc_valid_n)
         mon.push_back({19'h0, cmd_ident_bus_out, addr_data_check_bus_out, addr_data_bus_out});
   function automatic logic [31:0] mult(input logic [1:0] s);
      return s == 2'h0 ? 32'h8 : s == 2'h1 ? 32'h5 : s == 2'h2 ? 32'h4 : 32'h6;
   endfunction : mult
   function automatic logic [3:0] par4(input logic [31:0] w);
      return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
   endfunction : par4
   task automatic check(input logic [63:0] s, input logic [63:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   // one write; address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      check(s_axi_bresp, er);
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] q, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      q = s_axi_rdata;
      check(s_axi_rresp, er);
   endtask : rd
   task automatic wait_idle;
      do
         rd(SBI_STATUS, v, OK);
      while (v[0]);
   endtask : wait_idle
   task print_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard, far beyond the several hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      for (int s = 0; s < 4; s++)
      begin
         clock_ratio_strap <= s[1:0];
         byte_order_strap <= s[0] ^ s[1];
         aresetn <= 1'h0;
         repeat (12) @(posedge aclk);
         aresetn <= 1'h1;
         rd(SBI_CLK_MULT, v, OK);
         check(v, mult(s[1:0]));
         check(big_endian, s[0] ^ s[1]);
         rd(SBI_TIMER_CMP, v, OK);
         check(v, SBI_TIMER_CMP_RST);
      end
      wr(8'h2c, 32'h0, SBI_RESP_SLVERR);
      rd(8'hfc, v, SBI_RESP_SLVERR);
      // interrupt pins with line 5 handed to the pin
      for (int i = 0; i < 4; i++)
      begin
         p = (i == 0) ? 6'h3f : 6'($random(seed));
         irq_in_n <= ~p;
         repeat (3) @(posedge aclk);
         rd(SBI_EVENTS, v, OK);
         check(v[5:0], p);
      end
      // timer on: line 5 pin ignored, then the timer fires
      timer_irq_disable <= 1'h0;
      irq_in_n <= 6'h1f;
      repeat (3) @(posedge aclk);
      rd(SBI_EVENTS, v, OK);
      check(v[5:0], 6'h0);
      wr(SBI_TIMER_CMP, 32'h40, OK);
      repeat (100) @(posedge aclk);
      timer_irq_disable <= 1'h1;
      irq_in_n <= 6'h3f;
      nmi_in_n <= 1'h0;
      repeat (3) @(posedge aclk);
      nmi_in_n <= 1'h1;
      rd(SBI_EVENTS, v, OK);
      check(v[7:6], 2'h3);
      wr(SBI_EVENTS, 32'h1c0, OK);
      repeat (100) @(posedge aclk);
      rd(SBI_EVENTS, v, OK);
      check(v[7:6], 2'h0);
      // byte strobes keep the unselected lanes
      s_axi_wstrb <= 4'h5;
      wr(SBI_TIMER_CMP, 32'haabbccdd, OK);
      s_axi_wstrb <= 4'hf;
      rd(SBI_TIMER_CMP, v, OK);
      check(v, 32'h00bb_00dd);
      // halt then doze, each woken by an interrupt pin
      for (int m = 1; m < 3; m++)
      begin
         wr(SBI_CTRL, m, OK);
         check(low_power, 1'h1);
         irq_in_n <= 6'h3e;
         repeat (3) @(posedge aclk);
         check(low_power, 1'h0);
         irq_in_n <= 6'h3f;
      end
      // bus write then read, agent prompt or stalling, last read with bad parity
      for (int i = 0; i < 4; i++)
      begin
         slow <= i[0];
         bad_par <= (i == 3);
         a = $random(seed);
         d = $random(seed);
         c = 9'($random(seed));
         id = 9'($random(seed));
         rd_word <= $random(seed);
         rd_cmd <= 9'($random(seed));
         cmd_bus_parity_in <= i[1];
         wr(SBI_ADDR, a, OK);
         wr(SBI_WDATA, d, OK);
         wr(SBI_DATA_ID, {23'h0, id}, OK);
         mon.delete();
         wr(SBI_CMD, {22'h0, 1'h1, c}, OK);
         wait_idle();
         check(mon.size(), 2);
         check(mon[0], {19'h0, c, 4'h0, a});
         check(mon[1], {19'h0, id, par4(d), d});
         mon.delete();
         wr(SBI_CMD, {23'h0, c}, OK);
         wait_idle();
         check(mon.size(), 1);
         rd(SBI_RX_DATA, v, OK);
         check(v, rd_word);
         rd(SBI_RX_CMD, v, OK);
         check(v[8:0], rd_cmd);
         rd(SBI_EVENTS, v, OK);
         check(v[8], bad_par);
         wr(SBI_EVENTS, 32'h100, OK);
      end
      // stopped clock generator holds a launch; a second launch is refused
      pll_stop_n <= 1'h0;
      repeat (2) @(posedge aclk);
      check(core_clk_run, 1'h0);
      mon.delete();
      wr(SBI_CMD, 32'h200, OK);
      wr(SBI_CMD, 32'h200, SBI_RESP_SLVERR);
      rd(SBI_STATUS, v, OK);
      check({v[4], v[0]}, 2'h1);
      // enable low freezes the stop input
      ce <= 1'h0;
      pll_stop_n <= 1'h1;
      repeat (4) @(posedge aclk);
      check(core_clk_run, 1'h0);
      ce <= 1'h1;
      wait_idle();
      check(mon.size(), 2);
      // hand the interface over to the agent and take it back
      rd_word <= $random(seed);
      agent_bus_request_n <= 1'h0;
      while (release_n) @(posedge aclk);
      while (agent_valid_n) @(posedge aclk);
      rd(SBI_STATUS, v, OK);
      check(v[1], 1'h0);
      wr(SBI_CMD, 32'h0, SBI_RESP_SLVERR);
      agent_bus_request_n <= 1'h1;
      rd(SBI_STATUS, v, OK);
      rd(SBI_STATUS, v, OK);
      check(v[1], 1'h1);
      rd(SBI_RX_DATA, v, OK);
      check(v, rd_word);
      print_verdict();
   end
endmodule : sbi_sys_if_tb
